/* File: sffp_pkg.sv */
package sffp_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 5;
  localparam int ADDR_LSB = 10;
  localparam int DATA_W = 10;
  localparam int SCLK_DIV = 8;
  localparam int GAP_NS = 300;
  localparam int CLK_NS = 8;
  localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int FERR_BIT = 14;
  localparam logic [15:0] FERR_WORD = 16'hC000;
  localparam logic [13:0] FIRST_PAT = 14'h2AAA;
  localparam logic [ADDR_W-1:0] FLT_ADDR = 5'h06;
  localparam logic [3:0] FLT_RST = 4'h0;
endpackage

/* File: sffp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sffp_if;
  logic serial_clock;
  logic chip_select_n;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  modport dev (input serial_clock, input chip_select_n, input serial_in,
    output serial_out, output serial_out_oe);
  modport mst (output serial_clock, output chip_select_n,
    output serial_in, input serial_out, input serial_out_oe);
endinterface
`default_nettype wire

/* File: sffp_dev.sv */
`timescale 1ns/1ps
`default_nettype none
module sffp_dev
  import sffp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sffp_if.dev link,
  input wire logic [3:0] fault_raw,
  output logic [3:0] fault_out,
  output logic [WORD_W-1:0] cmd_word,
  output logic cmd_valid,
  input wire logic cmd_ready
);
  // Two-entry buffer between the frame decoder and the user side.
  logic [WORD_W-1:0] buf_q [2];
  logic [1:0] cnt_q;
  logic [1:0] cnt_d;
  logic wr_ptr_q;
  logic rd_ptr_q;
  logic [2:0] sck_s;
  logic [2:0] cs_s;
  logic [2:0] si_s;
  logic [WORD_W-1:0] rx_q;
  logic [WORD_W-1:0] tx_q;
  logic [WORD_W-1:0] reply_d;
  logic [5:0] bits_q;
  logic first_q;
  logic err_q;
  logic so_q;
  logic oe_q;
  logic [3:0] lay1_q;
  logic [3:0] lay2_q;
  logic [3:0] clr_q;
  logic [3:0] rep_q;
  logic push;
  logic pop;

  // The counter and the reply layout are built for one fixed word shape.
  if (WORD_W != 16 || ADDR_W + ADDR_LSB + 1 != WORD_W) begin : g_cfg_chk
    $error("sffp_dev: unsupported word layout");
  end

  // Edges are taken between the two settled stages, never the first one.
  function automatic logic f_rise(input logic [2:0] s);
    return s[1] & ~s[2];
  endfunction

  function automatic logic f_fall(input logic [2:0] s);
    return ~s[1] & s[2];
  endfunction

  wire sck_rise = f_rise(sck_s);
  wire sck_fall = f_fall(sck_s);
  wire cs_rise = f_rise(cs_s);
  wire cs_fall = f_fall(cs_s);
  wire frame_ok = (bits_q == 6'(WORD_W)) && ~^rx_q;
  wire is_flt = rx_q[WORD_W-1 -: ADDR_W] == FLT_ADDR;

  // The link inputs are only ever sampled; no clock or select leaves here.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sck_s <= '0;
      cs_s <= 3'b111;
      si_s <= '0;
    end else begin
      sck_s <= {sck_s[1:0], link.serial_clock};
      cs_s <= {cs_s[1:0], link.chip_select_n};
      si_s <= {si_s[1:0], link.serial_in};
    end
  end

  // The bit counter saturates so that a runaway clock burst cannot wrap
  // back to a count of sixteen and pass as a good frame.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_q <= '0;
      bits_q <= '0;
    end else if (cs_fall) begin
      bits_q <= '0;
    end else if (!cs_s[1] && sck_rise) begin
      rx_q <= {rx_q[WORD_W-2:0], si_s[1]};
      if (bits_q != 6'h3F) begin
        bits_q <= bits_q + 6'h01;
      end
    end
  end

  // The reply is fixed at select fall, so a fault command only changes
  // what the frame after the following one returns.
  always_comb begin
    if (first_q) begin
      reply_d = {2'b00, FIRST_PAT};
    end else if (err_q) begin
      reply_d = FERR_WORD;
    end else begin
      reply_d = {12'h000, lay2_q};
    end
  end

  // The first bit must stand before the first rising clock edge, so it is
  // put out at select fall and the rest follows each falling edge.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_q <= '0;
      so_q <= 1'b0;
    end else if (cs_fall) begin
      so_q <= reply_d[WORD_W-1];
      tx_q <= {reply_d[WORD_W-2:0], 1'b0};
    end else if (!cs_s[1] && sck_fall) begin
      so_q <= tx_q[WORD_W-1];
      tx_q <= {tx_q[WORD_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else if (cs_fall) begin
      oe_q <= 1'b1;
    end else if (cs_rise) begin
      oe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      first_q <= 1'b1;
      err_q <= 1'b0;
    end else if (cs_rise) begin
      first_q <= 1'b0;
      err_q <= ~frame_ok;
    end
  end

  // A report lasts one cycle, so a fault that comes back later is kept.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rep_q <= '0;
    end else if (cs_rise && frame_ok && is_flt) begin
      rep_q <= lay2_q;
    end else begin
      rep_q <= '0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clr_q <= '0;
    end else if (cs_rise && frame_ok && is_flt) begin
      clr_q <= rx_q[4:1];
    end else begin
      clr_q <= '0;
    end
  end

  // Set wins over clear so a live fault is never dropped.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lay1_q <= FLT_RST;
    end else begin
      lay1_q <= fault_raw | (lay1_q & ~clr_q & ~(rep_q & ~fault_raw));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lay2_q <= FLT_RST;
    end else if (cs_rise) begin
      lay2_q <= lay1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      fault_out <= '0;
    end else begin
      fault_out <= lay2_q;
    end
  end

  // A frame that arrives while both entries are taken is dropped; the
  // user side is expected to keep up through the cmd_valid handshake.
  assign push = cs_rise && frame_ok && cnt_q != 2'd2;
  assign pop = !cmd_valid && cnt_q != 2'd0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
    end else if (push) begin
      buf_q[wr_ptr_q] <= rx_q;
      wr_ptr_q <= ~wr_ptr_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_ptr_q <= 1'b0;
      cmd_valid <= 1'b0;
      cmd_word <= '0;
    end else if (cmd_valid && cmd_ready) begin
      cmd_valid <= 1'b0;
    end else if (pop) begin
      cmd_valid <= 1'b1;
      cmd_word <= buf_q[rd_ptr_q];
      rd_ptr_q <= ~rd_ptr_q;
    end
  end

  always_comb begin
    cnt_d = cnt_q + 2'(push) - 2'(pop);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // The pin itself is released by the output enable, not by a level.
  assign link.serial_out = so_q;
  assign link.serial_out_oe = oe_q;
endmodule // sffp_dev
`default_nettype wire

/* File: sffp_mst.sv */
`timescale 1ns/1ps
`default_nettype none
module sffp_mst
  import sffp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  sffp_if.mst link,
  input wire logic [WORD_W-1:0] req_word,
  input wire logic req_valid,
  output logic req_ready,
  output logic [WORD_W-1:0] rsp_word,
  output logic rsp_valid
);
  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_GAP} sffp_st_t;
  sffp_st_t st_q;
  logic [7:0] div_q, gap_q;
  logic [4:0] bit_q;
  logic [WORD_W-1:0] tx_q, rx_q;
  logic sck_q, cs_q, si_q;
  logic [1:0] so_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      so_s <= '0;
    end else begin
      so_s <= {so_s[0], link.serial_out};
    end
  end

  // Clock divided to 125/(2*SCLK_DIV) MHz, under the 10 MHz ceiling.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      div_q <= '0;
      gap_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      sck_q <= 1'b0;
      cs_q <= 1'b1;
      si_q <= 1'b0;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_word <= '0;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (req_valid && !req_ready) begin
            req_ready <= 1'b1;
            tx_q <= {req_word[WORD_W-2:0], 1'b0};
            si_q <= req_word[WORD_W-1];
            cs_q <= 1'b0;
            bit_q <= '0;
            div_q <= '0;
            st_q <= ST_LOW;
          end
        end
        ST_LOW: begin
          div_q <= div_q + 8'h01;
          if (div_q == 8'(SCLK_DIV - 1)) begin
            div_q <= '0;
            sck_q <= 1'b1;
            rx_q <= {rx_q[WORD_W-2:0], so_s[1]};
            st_q <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          div_q <= div_q + 8'h01;
          if (div_q == 8'(SCLK_DIV - 1)) begin
            div_q <= '0;
            sck_q <= 1'b0;
            if (bit_q == 5'(WORD_W - 1)) begin
              cs_q <= 1'b1;
              rsp_word <= rx_q;
              rsp_valid <= 1'b1;
              gap_q <= '0;
              st_q <= ST_GAP;
            end else begin
              bit_q <= bit_q + 5'h01;
              si_q <= tx_q[WORD_W-1];
              tx_q <= {tx_q[WORD_W-2:0], 1'b0};
              st_q <= ST_LOW;
            end
          end
        end
        ST_GAP: begin
          gap_q <= gap_q + 8'h01;
          if (gap_q == 8'(GAP_CYC)) begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign link.serial_clock = sck_q;
  assign link.chip_select_n = cs_q;
  assign link.serial_in = si_q;
endmodule // sffp_mst
`default_nettype wire

/* File: sffp_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sffp_monitor
  import sffp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic serial_clock,
  input wire logic chip_select_n,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic sck_q;
  logic [4:0] cnt_q;
  logic [7:0] gap_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk_sys) begin
    sck_q <= serial_clock;
    if (!rst_n || $fell(chip_select_n)) cnt_q <= 5'h00;
    else if (serial_clock && !sck_q) cnt_q <= cnt_q + 5'h01;
  end
  // Starts saturated so the first frame after reset is not flagged.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) gap_q <= 8'hFF;
    else if (!chip_select_n) gap_q <= 8'h00;
    else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
  end
  property p_len; $rose(chip_select_n) |-> cnt_q == 5'h10; endproperty
  a_len: assert property (p_len) else $error("bad clock count");
  property p_idle; chip_select_n |-> !serial_clock; endproperty
  a_idle: assert property (p_idle) else $error("clock outside frame");
  property p_gap; $fell(chip_select_n) |-> gap_q >= GAP_CYC; endproperty
  a_gap: assert property (p_gap) else $error("gap too short");
  property p_rate; $changed(serial_clock) |=> $stable(serial_clock) [*5];
  endproperty
  a_rate: assert property (p_rate) else $error("clock too fast");
  property p_si;
    !chip_select_n && $changed(serial_in) |-> !serial_clock;
  endproperty
  a_si: assert property (p_si) else $error("input moved high");
  property p_so;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
      |-> !serial_clock;
  endproperty
  a_so: assert property (p_so) else $error("output moved high");
  property p_on; $fell(chip_select_n) |-> ##[1:6] serial_out_oe; endproperty
  a_on: assert property (p_on) else $error("output not driven");
  property p_off; chip_select_n [*8] |-> !serial_out_oe; endproperty
  a_off: assert property (p_off) else $error("output not released");
  property p_cs; $rose(serial_out_oe) |-> !chip_select_n; endproperty
  a_cs: assert property (p_cs) else $error("drive while idle");
  cover property ($rose(chip_select_n));
  cover property ($rose(serial_out_oe));
  cover property ($fell(chip_select_n) && gap_q < 8'h40);
endmodule // sffp_monitor
`default_nettype wire

/* File: spi_slave_fault_flag_port_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_fault_flag_port_tb_top
  import sffp_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, req_valid = 1'b0, cmd_ready = 1'b0;
  logic req_ready, rsp_valid, cmd_valid;
  logic [3:0] fault_raw = 4'h0, fault_out;
  logic [15:0] req_word = 16'h0000, rsp_word, cmd_word;
  logic [31:0] rs = 32'h0000_3990;
  logic [15:0] exp_cmd[$];
  int n_fail = 0, comparisons = 0;
  sffp_if link ();
  always #4 clk_sys = ~clk_sys;
  sffp_mst sffp_mst_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .req_word(req_word), .req_valid(req_valid), .req_ready(req_ready),
    .rsp_word(rsp_word), .rsp_valid(rsp_valid));
  sffp_dev sffp_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .link(link),
    .fault_raw(fault_raw), .fault_out(fault_out), .cmd_word(cmd_word),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));
  sffp_monitor sffp_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .serial_clock(link.serial_clock), .chip_select_n(link.chip_select_n),
    .serial_in(link.serial_in), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe));
  task conclude();
    $display("n_fail %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Random even-parity command that keeps clear of the fault address.
  function automatic logic [15:0] good();
    logic [15:0] w;
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    w = rs[15:0];
    if (w[15:11] == FLT_ADDR) w[15] = ~w[15];
    w[0] = ^w[15:1];
    return w;
  endfunction
  task xfer(input logic [15:0] w, input bit on, input logic [15:0] e);
    int i;
    i = 0;
    req_word = w;
    req_valid = 1'b1;
    do begin
      @(posedge clk_sys);
      #1 i++;
    end while (req_ready !== 1'b1 && i < 100);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 2000) begin
      @(posedge clk_sys);
      #1 i++;
    end
    if (i >= 2000) begin
      n_fail++;
      conclude();
    end
    if (on) chk(rsp_word, e);
    repeat (8) @(posedge clk_sys);
    #1;
  endtask
  always @(posedge clk_sys) begin
    if (rst_n && cmd_valid === 1'b1 && cmd_ready === 1'b1)
      chk(cmd_word, exp_cmd.size() ? exp_cmd.pop_front() : 16'hxxxx);
  end
  task push_x(input bit on, input logic [15:0] e);
    logic [15:0] w;
    w = good();
    exp_cmd.push_back(w);
    xfer(w, on, e);
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cmd_ready = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 push_x(1, {2'b00, FIRST_PAT});
    xfer(good() ^ 16'h0001, 1, 16'h0000);
    push_x(1, FERR_WORD);
    cmd_ready = 1'b0;
    // The fourth stalled word must be dropped, not overwrite the buffer.
    for (int k = 0; k < 4; k++) begin
      if (k < 3) push_x(1, 16'h0000);
      else xfer(good(), 1, 16'h0000);
    end
    cmd_ready = 1'b1;
    fault_raw = 4'h5;
    repeat (3) @(posedge clk_sys);
    #1 fault_raw = 4'h0;
    push_x(1, 16'h0000);
    chk({12'h000, fault_out}, 16'h0005);
    exp_cmd.push_back({FLT_ADDR, 11'h000});
    xfer({FLT_ADDR, 11'h000}, 1, 16'h0005);
    push_x(0, 16'h0000);
    chk({12'h000, fault_out}, 16'h0000);
    fault_raw = 4'h2;
    repeat (3) @(posedge clk_sys);
    #1 fault_raw = 4'h0;
    exp_cmd.push_back(16'h3005);
    xfer(16'h3005, 1, 16'h0000);
    chk({12'h000, fault_out}, 16'h0002);
    push_x(1, 16'h0002);
    chk({12'h000, fault_out}, 16'h0000);
    push_x(1, 16'h0000);
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 push_x(1, {2'b00, FIRST_PAT});
    chk(16'(exp_cmd.size()), 16'h0000);
    conclude();
  end
endmodule // spi_slave_fault_flag_port_tb_top
`default_nettype wire
